//--- core/ira_defs.svh
// constants for the id rom access and version block
`ifndef IRA_DEFS_SVH
`define IRA_DEFS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define IRA_OFS_VERSION   8'h00
`define IRA_OFS_ROM       8'h04
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IRA_BIT_PRESENT   24
`define IRA_BIT_CLEAR     31
`define IRA_BIT_GO        25
`define IRA_BYTE_HI       23
`define IRA_BYTE_LO       16
// ----------------------------------------------------------------------
// constant codes and reset values
// ----------------------------------------------------------------------
`define IRA_VER_MAJOR     8'h3c   // arbitrary value
`define IRA_VER_MINOR     8'h0a   // arbitrary value
`define IRA_ADDR_RST      8'h00
`define IRA_BYTE_RST      8'h00
// ----------------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------------
`define IRA_SYNC_WAIT     2'h2
`define IRA_BIL_BYTES     8'h14
`endif

//--- core/ira_pkg.sv
// types for the id rom access and version block
package ira_pkg;
    typedef enum logic [2:0] {
        IRA_BOOT = 3'b000,
        IRA_LOAD = 3'b001,
        IRA_IDLE = 3'b010,
        IRA_READ = 3'b011
    } ira_state_e;

    typedef struct packed {
        logic       req;
        logic [7:0] addr;
    } ira_romreq_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] index;
        logic [7:0] data;
    } ira_bil_s;
endpackage

//--- core/ira_top.sv
// version register and byte read port into the id eeprom
`timescale 1ns/10ps
`include "ira_defs.svh"
module ira_top
    import ira_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        REG_RD,
    input  wire logic        REG_WR,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    output logic             REG_RVALID,
    input  wire logic        ROM_DETECT,
    output ira_romreq_s      ROM_REQ,
    input  wire logic        ROM_ACK,
    input  wire logic [7:0]  ROM_DATA,
    output ira_bil_s         BIL_OUT,
    output logic             BIL_DONE
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic        det_s1_ff;
    logic        det_s2_ff;
    logic        present_ff,  nxt_present;
    logic [1:0]  boot_cnt_ff, nxt_boot_cnt;
    ira_state_e  state_ff,    nxt_state;
    ira_romreq_s romreq_ff,   nxt_romreq;
    ira_bil_s    bil_ff,      nxt_bil;
    logic        bil_done_ff, nxt_bil_done;
    logic [7:0]  rom_addr_ff, nxt_rom_addr;
    logic [7:0]  rd_byte_ff,  nxt_rd_byte;
    logic        clear_ff,    nxt_clear;
    logic        go_ff,       nxt_go;
    logic [31:0] rdata_ff,    nxt_rdata;
    logic        rvalid_ff,   nxt_rvalid;
    logic [7:0]  rd_addr_ff,  nxt_rd_addr;

    // read value of one register offset
    function automatic logic [31:0] reg_value(input logic [7:0] ofs, input logic pres,
                                              input logic clr, input logic go,
                                              input logic [7:0] rb);
        logic [31:0] v;
        v = 32'h0;
        if (ofs == `IRA_OFS_VERSION) begin
            v[`IRA_BIT_PRESENT] = pres;
            v[`IRA_BYTE_HI:`IRA_BYTE_LO] = `IRA_VER_MAJOR;
            v[7:0] = `IRA_VER_MINOR;
        end else if (ofs == `IRA_OFS_ROM) begin
            v[`IRA_BIT_CLEAR] = clr;
            v[`IRA_BIT_GO] = go;
            v[`IRA_BYTE_HI:`IRA_BYTE_LO] = rb;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // detect pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            det_s1_ff <= 1'b0;
            det_s2_ff <= 1'b0;
        end else begin
            det_s1_ff <= ROM_DETECT;
            det_s2_ff <= det_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // sequencer and register next values
    // ------------------------------------------------------------------
    always_comb begin
        nxt_present  = present_ff;
        nxt_boot_cnt = boot_cnt_ff;
        nxt_state    = state_ff;
        nxt_romreq   = romreq_ff;
        nxt_bil      = bil_ff;
        nxt_bil.valid = 1'b0;
        nxt_bil_done = bil_done_ff;
        nxt_rom_addr = rom_addr_ff;
        nxt_rd_byte  = rd_byte_ff;
        nxt_clear    = clear_ff;
        nxt_go       = go_ff;
        nxt_rvalid   = REG_RD;
        nxt_rd_addr  = REG_RD ? REG_ADDR : rd_addr_ff;
        nxt_rdata    = REG_RD ? reg_value(REG_ADDR, present_ff, clear_ff, go_ff, rd_byte_ff)
                              : rdata_ff;
        unique case (state_ff)
            IRA_BOOT: begin
                // wait for synchronised detect level, then sample it
                if (boot_cnt_ff == `IRA_SYNC_WAIT) begin
                    nxt_present = det_s2_ff;
                    if (det_s2_ff) begin
                        nxt_state       = IRA_LOAD;
                        nxt_romreq.req  = 1'b1;
                        nxt_romreq.addr = 8'h00;
                    end else begin
                        nxt_state    = IRA_IDLE;
                        nxt_bil_done = 1'b1;
                    end
                end else begin
                    nxt_boot_cnt = boot_cnt_ff + 2'h1;
                end
            end
            IRA_LOAD: begin
                // stream bus info bytes out as they arrive
                if (ROM_ACK) begin
                    nxt_bil.valid = 1'b1;
                    nxt_bil.index = romreq_ff.addr;
                    nxt_bil.data  = ROM_DATA;
                    if (romreq_ff.addr == `IRA_BIL_BYTES - 8'h01) begin
                        nxt_romreq.req = 1'b0;
                        nxt_state      = IRA_IDLE;
                        nxt_bil_done   = 1'b1;
                    end else begin
                        nxt_romreq.addr = romreq_ff.addr + 8'h01;
                    end
                end
            end
            IRA_IDLE: begin
                // pending clear served before a pending read
                if (clear_ff) begin
                    nxt_rom_addr = `IRA_ADDR_RST;
                    nxt_clear    = 1'b0;
                end else if (go_ff) begin
                    nxt_state       = IRA_READ;
                    nxt_romreq.req  = 1'b1;
                    nxt_romreq.addr = rom_addr_ff;
                end
            end
            IRA_READ: begin
                if (ROM_ACK) begin
                    nxt_rd_byte    = ROM_DATA;
                    nxt_go         = 1'b0;
                    nxt_rom_addr   = rom_addr_ff + 8'h01;
                    nxt_romreq.req = 1'b0;
                    nxt_state      = IRA_IDLE;
                end
            end
            default: nxt_state = IRA_IDLE;
        endcase
        // software sets win over self-clear; ignored without eeprom
        if (REG_WR && REG_ADDR == `IRA_OFS_ROM && present_ff) begin
            if (REG_WDATA[`IRA_BIT_CLEAR]) nxt_clear = 1'b1;
            if (REG_WDATA[`IRA_BIT_GO]) nxt_go = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            present_ff  <= 1'b0;
            boot_cnt_ff <= 2'h0;
            state_ff    <= IRA_BOOT;
            romreq_ff   <= '0;
            bil_ff      <= '0;
            bil_done_ff <= 1'b0;
            rom_addr_ff <= `IRA_ADDR_RST;
            rd_byte_ff  <= `IRA_BYTE_RST;
            clear_ff    <= 1'b0;
            go_ff       <= 1'b0;
            rdata_ff    <= 32'h0;
            rvalid_ff   <= 1'b0;
            rd_addr_ff  <= 8'h00;
        end else begin
            present_ff  <= nxt_present;
            boot_cnt_ff <= nxt_boot_cnt;
            state_ff    <= nxt_state;
            romreq_ff   <= nxt_romreq;
            bil_ff      <= nxt_bil;
            bil_done_ff <= nxt_bil_done;
            rom_addr_ff <= nxt_rom_addr;
            rd_byte_ff  <= nxt_rd_byte;
            clear_ff    <= nxt_clear;
            go_ff       <= nxt_go;
            rdata_ff    <= nxt_rdata;
            rvalid_ff   <= nxt_rvalid;
            rd_addr_ff  <= nxt_rd_addr;
        end
    end

    // output drive
    assign REG_RDATA  = rdata_ff;
    assign REG_RVALID = rvalid_ff;
    assign ROM_REQ    = romreq_ff;
    assign BIL_OUT    = bil_ff;
    assign BIL_DONE   = bil_done_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_ver_top_zero: assert property (@(posedge CLK) disable iff (RST)
        (rvalid_ff && rd_addr_ff == `IRA_OFS_VERSION) |-> rdata_ff[31:25] == 7'h0)
        else $error("version top bits not zero");
    a_ver_present: assert property (@(posedge CLK) disable iff (RST)
        (rvalid_ff && rd_addr_ff == `IRA_OFS_VERSION) |-> rdata_ff[24] == $past(present_ff))
        else $error("present flag mismatch");
    a_auto_load: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_BOOT && boot_cnt_ff == `IRA_SYNC_WAIT && det_s2_ff)
        |=> state_ff == IRA_LOAD && romreq_ff.req && romreq_ff.addr == 8'h00)
        else $error("auto load not started");
    a_ver_major: assert property (@(posedge CLK) disable iff (RST)
        (rvalid_ff && rd_addr_ff == `IRA_OFS_VERSION) |-> rdata_ff[23:16] == `IRA_VER_MAJOR)
        else $error("major version wrong");
    a_ver_minor: assert property (@(posedge CLK) disable iff (RST)
        (rvalid_ff && rd_addr_ff == `IRA_OFS_VERSION) |-> rdata_ff[7:0] == `IRA_VER_MINOR)
        else $error("minor version wrong");
    a_ver_mid_zero: assert property (@(posedge CLK) disable iff (RST)
        (rvalid_ff && rd_addr_ff == `IRA_OFS_VERSION) |-> rdata_ff[15:8] == 8'h0)
        else $error("version middle byte not zero");
    a_clear_addr: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_IDLE && clear_ff) |=> rom_addr_ff == 8'h00)
        else $error("address not cleared");
    a_clear_self: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_IDLE && clear_ff && !REG_WR) |=> !clear_ff)
        else $error("clear bit stuck");
    a_clear_keep: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_IDLE && clear_ff) |=> $stable(rd_byte_ff))
        else $error("read byte changed on clear");
    a_go_start: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_IDLE && go_ff && !clear_ff)
        |=> state_ff == IRA_READ && romreq_ff.addr == $past(rom_addr_ff))
        else $error("read not started");
    a_go_hold: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_READ && !ROM_ACK) |=> go_ff && state_ff == IRA_READ)
        else $error("go dropped early");
    a_byte_done: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_READ && ROM_ACK)
        |=> !go_ff && rd_byte_ff == $past(ROM_DATA) && state_ff == IRA_IDLE)
        else $error("fetched byte not stored");
    a_rom_reserved_bits: assert property (@(posedge CLK) disable iff (RST)
        (rvalid_ff && rd_addr_ff == `IRA_OFS_ROM)
        |-> rdata_ff[30:26] == 5'h0 && !rdata_ff[24] && rdata_ff[15:0] == 16'h0)
        else $error("rom reserved bits not zero");
    a_addr_step: assert property (@(posedge CLK) disable iff (RST)
        (state_ff == IRA_READ && ROM_ACK) |=> rom_addr_ff == $past(rom_addr_ff) + 8'h01)
        else $error("address not advanced");
endmodule // ira_top

//--- verif/ira_rom_model.sv
// eeprom serial engine model answering byte requests after a set latency
`timescale 1ns/10ps
module ira_rom_model
    import ira_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire ira_romreq_s rom_req,
    input  wire logic [3:0]  wait_cycles,
    output logic             rom_ack,
    output logic [7:0]       rom_data
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic       ack_ff, nxt_ack;
    logic [7:0] data_ff, nxt_data;

    // latency count, one-cycle ack, data line toggles when not answering
    always_comb begin
        nxt_cnt  = 4'h0;
        nxt_ack  = 1'b0;
        nxt_data = ~data_ff;
        if (!ack_ff && rom_req.req) begin
            if (cnt_ff == wait_cycles) begin
                nxt_ack  = 1'b1;
                nxt_data = rom_req.addr ^ 8'h5a;  // byte content
            end else begin
                nxt_cnt = cnt_ff + 4'h1;
            end
        end
    end

    // register state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_ff  <= 4'h0;
            ack_ff  <= 1'b0;
            data_ff <= 8'h00;
        end else begin
            cnt_ff  <= nxt_cnt;
            ack_ff  <= nxt_ack;
            data_ff <= nxt_data;
        end
    end

    assign rom_ack  = ack_ff;
    assign rom_data = data_ff;
endmodule // ira_rom_model

//--- verif/tb_ira_top.sv
// self-checking bench for the id rom access and version block
`timescale 1ns/10ps
`include "ira_defs.svh"
module tb_ira_top;
    import ira_pkg::*;
    logic        CLK = 0, RST = 1, REG_RD = 0, REG_WR = 0, ROM_DETECT = 1;
    logic [7:0]  REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rd;
    logic        REG_RVALID, ROM_ACK, BIL_DONE;
    logic [7:0]  ROM_DATA, exp_addr;
    logic [3:0]  wait_cycles = 4'h2;
    ira_romreq_s ROM_REQ;
    ira_bil_s    BIL_OUT;
    int          err_count = 0, tests_run = 0, cycles = 0, bil_count = 0;

    ira_top ira_top_i (.CLK(CLK), .RST(RST), .REG_RD(REG_RD), .REG_WR(REG_WR),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .ROM_DETECT(ROM_DETECT), .ROM_REQ(ROM_REQ),
        .ROM_ACK(ROM_ACK), .ROM_DATA(ROM_DATA), .BIL_OUT(BIL_OUT), .BIL_DONE(BIL_DONE));
    ira_rom_model ira_rom_model_i (.CLK(CLK), .RST(RST), .rom_req(ROM_REQ),
        .wait_cycles(wait_cycles), .rom_ack(ROM_ACK), .rom_data(ROM_DATA));

    always #2 CLK = ~CLK;

    // ----------------------------------------------------------------
    // compare, verdict and hang guard
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict;
        end
    end

    // auto-loaded bytes come in order with the addressed content, sampled mid-cycle
    always @(negedge CLK) begin
        if (BIL_OUT.valid === 1'b1) begin
            check("bil_index", 32'(bil_count), {24'h0, BIL_OUT.index});
            check("bil_data", {24'h0, BIL_OUT.index ^ 8'h5a}, {24'h0, BIL_OUT.data});
            bil_count++;
        end
    end

    // ----------------------------------------------------------------
    // register port tasks
    // ----------------------------------------------------------------
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        #1 REG_RD = 1;
        REG_ADDR = a;
        @(posedge CLK);
        #1 REG_RD = 0;
        check("rvalid", 32'h1, {31'h0, REG_RVALID});
        d = REG_RDATA;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        #1 REG_WR = 1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(posedge CLK);
        #1 REG_WR = 0;
    endtask

    // software polls the self-clearing bit before using the byte
    task automatic poll_clear(input int b);
        int n;
        n = 0;
        reg_rd(`IRA_OFS_ROM, rd);
        while (rd[b] !== 1'b0 && n < 100) begin
            reg_rd(`IRA_OFS_ROM, rd);
            n++;
        end
        check("self_clear", 32'h0, {31'h0, rd[b]});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_boot(input logic det);
        int n;
        ROM_DETECT = det;
        RST = 1;
        bil_count = 0;
        exp_addr = 8'h00;
        repeat (10) @(posedge CLK);
        #1 RST = 0;
        n = 0;
        // done flag looked at once settled after each edge
        while (BIL_DONE !== 1'b1 && n < 400) begin
            @(posedge CLK);
            #1 n++;
        end
        // let the monitor count the last byte first
        @(negedge CLK);
        #1 check("bil_count", det ? 32'(`IRA_BIL_BYTES) : 32'h0, 32'(bil_count));
        check("bil_done", 32'h1, {31'h0, BIL_DONE});
        reg_rd(`IRA_OFS_VERSION, rd);
        check("version", {7'h0, det, `IRA_VER_MAJOR, 8'h00, `IRA_VER_MINOR}, rd);
        reg_rd(8'h08, rd);
        check("unmapped", 32'h0, rd);
    endtask

    task automatic test_reads(input int cnt, input logic [3:0] wt);
        wait_cycles = wt;
        for (int i = 0; i < cnt; i++) begin
            reg_wr(`IRA_OFS_ROM, 32'h0200_0000);
            reg_rd(`IRA_OFS_ROM, rd);
            check("go_busy", 32'h1, {31'h0, rd[`IRA_BIT_GO]});
            poll_clear(`IRA_BIT_GO);
            check("rom_word", {8'h0, exp_addr ^ 8'h5a, 16'h0}, rd);
            exp_addr = exp_addr + 8'h01;
        end
    endtask

    task automatic test_clear;
        logic [7:0] prev;
        prev = rd[23:16];
        reg_wr(`IRA_OFS_ROM, 32'h8000_0000);
        poll_clear(`IRA_BIT_CLEAR);
        check("byte_kept", {8'h0, prev, 16'h0}, rd);
        exp_addr = 8'h00;
        test_reads(1, 4'h1);
    endtask

    task automatic test_absent;
        test_boot(1'b0);
        reg_wr(`IRA_OFS_ROM, 32'h0200_0000);
        repeat (5) @(posedge CLK);
        #1 check("req_idle", 32'h0, {31'h0, ROM_REQ.req});
        reg_rd(`IRA_OFS_ROM, rd);
        check("go_ignored", 32'h0, {31'h0, rd[`IRA_BIT_GO]});
    endtask

    initial begin
        test_boot(1'b1);
        test_reads(3, 4'h2);
        test_clear;
        test_reads(2, 4'h9);
        test_absent;
        give_verdict;
    end
endmodule // tb_ira_top
